// ### common/pfil_pkg.sv
// Package: command codes, reset values, field layout and decode helpers
package pfil_pkg;

   // ----------------------------------------------------------------
   // Command codes
   // ----------------------------------------------------------------
   localparam logic [7:0]  CMD_PHASE_CFG  = 8'hf5;
   localparam logic [7:0]  CMD_FREQ_SEL   = 8'h33;
   localparam logic [7:0]  CMD_VIN_START  = 8'h35;
   localparam logic [7:0]  CMD_VIN_STOP   = 8'h36;
   localparam logic [7:0]  CMD_VIN_OV     = 8'h55;
   localparam logic [7:0]  CMD_VIN_UV     = 8'h58;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_PHASE_CFG  = 8'h10;
   localparam logic [15:0] RST_FREQ_SEL   = 16'hfabc;
   localparam logic [15:0] RST_VIN_START  = 16'hcb40;
   localparam logic [15:0] RST_VIN_STOP   = 16'hcb00;
   localparam logic [15:0] RST_VIN_OV     = 16'hd3e0;
   localparam logic [15:0] RST_VIN_UV     = 16'hcb26;

   // ----------------------------------------------------------------
   // Field layout and sizes
   // ----------------------------------------------------------------
   localparam int          PH_GANG_BIT    = 7;
   localparam int          PH_SHARE_BIT   = 4;
   localparam logic [7:0]  PH_WR_MASK     = 8'h97;
   localparam logic [2:0]  PH_CODE_BAD    = 3'h7;
   localparam logic [1:0]  LEN_BYTE       = 2'h1;
   localparam logic [1:0]  LEN_WORD       = 2'h2;

   // ----------------------------------------------------------------
   // Frequency select decode: {valid, ext_osc, khz[9:0]}
   // ----------------------------------------------------------------
   function automatic logic [11:0] freq_decode(input logic [15:0] w);
      logic [11:0] r;
      r = 12'h000;
      if (w == 16'h0000) r = 12'hc00;
      else if (w == 16'hf3e8) r = {2'h2, 10'd250};
      else if (w == 16'hfabc) r = {2'h2, 10'd350};
      else if (w == 16'hfb52) r = {2'h2, 10'd425};
      else if (w == 16'hfbe8) r = {2'h2, 10'd500};
      else if (w == 16'h023f) r = {2'h2, 10'd575};
      else if (w == 16'h028a) r = {2'h2, 10'd650};
      else if (w == 16'h02ee) r = {2'h2, 10'd750};
      else if (w == 16'h03e8) r = {2'h2, 10'd1000};
      return r;
   endfunction : freq_decode

   // Linear 5-bit exponent / 11-bit mantissa to common fixed point
   function automatic logic signed [47:0] lin_to_fix(input logic [15:0] w);
      logic signed [47:0] m;
      logic [4:0]         sh;
      m  = {{37{w[10]}}, w[10:0]};
      sh = {~w[15], w[14:11]};
      return m <<< sh;
   endfunction : lin_to_fix

endpackage : pfil_pkg

// ### rtl/pfil_cmd_regs.sv
// Command register bank: phase, frequency and input voltage limits
`timescale 1ns/1ps
`default_nettype none
module pfil_cmd_regs
(
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic        lnk_clk,
   input  wire logic        lnk_rst_b,
   input  wire logic        lnk_req,
   input  wire logic        lnk_wr,
   input  wire logic [7:0]  lnk_cmd,
   input  wire logic [1:0]  lnk_nbytes,
   input  wire logic [15:0] lnk_wdata,
   output logic             lnk_ready,
   output logic             lnk_done,
   output logic [15:0]      lnk_rdata,
   output logic             lnk_busy_err,
   output logic             lnk_cml_err,
   input  wire logic [1:0]  run_pin,
   input  wire logic [1:0]  chan_cmd_on,
   input  wire logic        vin_sample_vld,
   input  wire logic [15:0] vin_sample,
   input  wire logic        clear_faults,
   output logic [2:0]       phase_code,
   output logic [8:0]       ch0_phase_deg,
   output logic [8:0]       ch1_phase_deg,
   output logic             ea_gang,
   output logic [9:0]       freq_khz,
   output logic             freq_ext_osc,
   output logic             freq_changed,
   output logic             share_clk_o,
   output logic             share_clk_oe_b,
   output logic             vin_ov_fault,
   output logic             vin_uv_warn,
   output logic             busy_fault,
   output logic             cml_fault
);

   // ----------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        req_tgl;
      logic        pend;
      logic        wr;
      logic [7:0]  cmd;
      logic [1:0]  nbytes;
      logic [15:0] wdata;
      logic        ack_s1;
      logic        ack_s2;
      logic        ack_s3;
      logic        done;
      logic [15:0] rdata;
      logic        busy;
      logic        cml;
   } pfil_lnk_t;

   typedef struct packed {
      logic [1:0]  run_s1;
      logic [1:0]  run_s2;
      logic        req_s1;
      logic        req_s2;
      logic        req_s3;
      logic        ack_tgl;
      logic [15:0] rdata;
      logic        rsp_busy;
      logic        rsp_cml;
      logic [7:0]  phase;
      logic [15:0] freq;
      logic [15:0] input_start_threshold;
      logic [15:0] input_stop_threshold;
      logic [15:0] vin_ov;
      logic [15:0] vin_uv;
      logic        ov_fault;
      logic        uv_warn;
      logic        busy_f;
      logic        cml_f;
      logic        vin_ok;
      logic        vin_seen;
      logic        freq_chg;
   } pfil_core_t;

   pfil_lnk_t  l_q, l_d;
   pfil_core_t c_q, c_d;

   // ----------------------------------------------------------------
   // Link domain: request capture and answer return
   // ----------------------------------------------------------------
   assign lnk_ready = ~l_q.pend;

   always_comb
   begin
      l_d        = l_q;
      l_d.done   = 1'b0;
      l_d.ack_s1 = c_q.ack_tgl;
      l_d.ack_s2 = l_q.ack_s1;
      l_d.ack_s3 = l_q.ack_s2;
      if (lnk_req && !l_q.pend)
      begin
         l_d.pend    = 1'b1;
         l_d.wr      = lnk_wr;
         l_d.cmd     = lnk_cmd;
         l_d.nbytes  = lnk_nbytes;
         l_d.wdata   = lnk_wdata;
         l_d.req_tgl = ~l_q.req_tgl;
      end
      if (l_q.pend && (l_q.ack_s2 != l_q.ack_s3))
      begin
         l_d.pend  = 1'b0;
         l_d.done  = 1'b1;
         l_d.rdata = c_q.rdata;
         l_d.busy  = c_q.rsp_busy;
         l_d.cml   = c_q.rsp_cml;
      end
   end

   always_ff @(posedge lnk_clk)
   begin
      if (!lnk_rst_b)
         l_q <= '0;
      else
         l_q <= l_d;
   end

   assign lnk_done     = l_q.done;
   assign lnk_rdata    = l_q.rdata;
   assign lnk_busy_err = l_q.busy;
   assign lnk_cml_err  = l_q.cml;

   // ----------------------------------------------------------------
   // Core domain: decode, limits and monitor
   // ----------------------------------------------------------------
   logic               req_evt;
   logic               running;
   logic               is_phase;
   logic               is_freq;
   logic               known;
   logic               size_ok;
   logic [11:0]        fdec_wr;
   logic [11:0]        fdec_q;
   logic signed [47:0] vin_fix;

   assign req_evt  = c_q.req_s2 ^ c_q.req_s3;
   assign running  = |(c_q.run_s2 & chan_cmd_on);
   assign is_phase = (l_q.cmd == pfil_pkg::CMD_PHASE_CFG);
   assign is_freq  = (l_q.cmd == pfil_pkg::CMD_FREQ_SEL);
   assign known    = is_phase || is_freq
                     || (l_q.cmd == pfil_pkg::CMD_VIN_START)
                     || (l_q.cmd == pfil_pkg::CMD_VIN_STOP)
                     || (l_q.cmd == pfil_pkg::CMD_VIN_OV)
                     || (l_q.cmd == pfil_pkg::CMD_VIN_UV);
   assign size_ok  = is_phase ? (l_q.nbytes == pfil_pkg::LEN_BYTE)
                              : (l_q.nbytes == pfil_pkg::LEN_WORD);
   assign fdec_wr  = pfil_pkg::freq_decode(l_q.wdata);
   assign fdec_q   = pfil_pkg::freq_decode(c_q.freq);
   assign vin_fix  = pfil_pkg::lin_to_fix(vin_sample);

   always_comb
   begin
      c_d          = c_q;
      c_d.run_s1   = run_pin;
      c_d.run_s2   = c_q.run_s1;
      c_d.req_s1   = l_q.req_tgl;
      c_d.req_s2   = c_q.req_s1;
      c_d.req_s3   = c_q.req_s2;
      c_d.freq_chg = 1'b0;
      if (clear_faults)
      begin
         c_d.ov_fault = 1'b0;
         c_d.uv_warn  = 1'b0;
         c_d.busy_f   = 1'b0;
         c_d.cml_f    = 1'b0;
      end
      if (req_evt)
      begin
         c_d.ack_tgl  = ~c_q.ack_tgl;
         c_d.rdata    = 16'h0000;
         c_d.rsp_busy = 1'b0;
         c_d.rsp_cml  = 1'b0;
         if (!known || !size_ok)
            c_d.rsp_cml = 1'b1;
         else if (!l_q.wr)
         begin
            if (is_phase)
               c_d.rdata = {8'h00, c_q.phase};
            else if (is_freq)
               c_d.rdata = c_q.freq;
            else if (l_q.cmd == pfil_pkg::CMD_VIN_START)
               c_d.rdata = c_q.input_start_threshold;
            else if (l_q.cmd == pfil_pkg::CMD_VIN_STOP)
               c_d.rdata = c_q.input_stop_threshold;
            else if (l_q.cmd == pfil_pkg::CMD_VIN_OV)
               c_d.rdata = c_q.vin_ov;
            else
               c_d.rdata = c_q.vin_uv;
         end
         else if ((is_phase || is_freq) && running)
            c_d.rsp_busy = 1'b1;
         else if (is_phase && (l_q.wdata[2:0] == pfil_pkg::PH_CODE_BAD))
            c_d.rsp_cml = 1'b1;
         else if (is_freq && !fdec_wr[11])
            c_d.rsp_cml = 1'b1;
         else if (is_phase)
            c_d.phase = l_q.wdata[7:0] & pfil_pkg::PH_WR_MASK;
         else if (is_freq)
         begin
            c_d.freq     = l_q.wdata;
            c_d.freq_chg = (l_q.wdata != c_q.freq);
         end
         else if (l_q.cmd == pfil_pkg::CMD_VIN_START)
            c_d.input_start_threshold = l_q.wdata;
         else if (l_q.cmd == pfil_pkg::CMD_VIN_STOP)
            c_d.input_stop_threshold = l_q.wdata;
         else if (l_q.cmd == pfil_pkg::CMD_VIN_OV)
            c_d.vin_ov = l_q.wdata;
         else
            c_d.vin_uv = l_q.wdata;
         if (c_d.rsp_busy)
            c_d.busy_f = 1'b1;
         if (c_d.rsp_cml)
            c_d.cml_f = 1'b1;
      end
      if (vin_sample_vld)
      begin
         if (vin_fix > pfil_pkg::lin_to_fix(c_q.vin_ov))
            c_d.ov_fault = 1'b1;
         if (vin_fix <= pfil_pkg::lin_to_fix(c_q.vin_uv))
            c_d.uv_warn = 1'b1;
         if (vin_fix > pfil_pkg::lin_to_fix(c_q.input_start_threshold))
         begin
            c_d.vin_ok   = 1'b1;
            c_d.vin_seen = 1'b1;
         end
         else if (vin_fix < pfil_pkg::lin_to_fix(c_q.input_stop_threshold))
            c_d.vin_ok = 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         c_q         <= '0;
         c_q.phase   <= pfil_pkg::RST_PHASE_CFG;
         c_q.freq    <= pfil_pkg::RST_FREQ_SEL;
         c_q.input_start_threshold  <= pfil_pkg::RST_VIN_START;
         c_q.input_stop_threshold <= pfil_pkg::RST_VIN_STOP;
         c_q.vin_ov  <= pfil_pkg::RST_VIN_OV;
         c_q.vin_uv  <= pfil_pkg::RST_VIN_UV;
      end
      else
         c_q <= c_d;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_comb
   begin
      ch0_phase_deg = 9'd0;
      ch1_phase_deg = 9'd180;
      case (c_q.phase[2:0])
         3'h1:    begin ch0_phase_deg = 9'd90;  ch1_phase_deg = 9'd270; end
         3'h2:    begin ch0_phase_deg = 9'd0;   ch1_phase_deg = 9'd240; end
         3'h3:    begin ch0_phase_deg = 9'd0;   ch1_phase_deg = 9'd120; end
         3'h4:    begin ch0_phase_deg = 9'd120; ch1_phase_deg = 9'd240; end
         3'h5:    begin ch0_phase_deg = 9'd60;  ch1_phase_deg = 9'd240; end
         3'h6:    begin ch0_phase_deg = 9'd120; ch1_phase_deg = 9'd300; end
         default: begin ch0_phase_deg = 9'd0;   ch1_phase_deg = 9'd180; end
      endcase
   end

   assign phase_code     = c_q.phase[2:0];
   assign ea_gang        = c_q.phase[pfil_pkg::PH_GANG_BIT];
   assign freq_khz       = fdec_q[9:0];
   assign freq_ext_osc   = fdec_q[10];
   assign freq_changed   = c_q.freq_chg;
   assign share_clk_o    = 1'b0;
   assign share_clk_oe_b = c_q.phase[pfil_pkg::PH_SHARE_BIT] ? c_q.vin_ok
                                                             : c_q.vin_seen;
   assign vin_ov_fault   = c_q.ov_fault;
   assign vin_uv_warn    = c_q.uv_warn;
   assign busy_fault     = c_q.busy_f;
   assign cml_fault      = c_q.cml_f;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence s_wr_run;
      req_evt && l_q.wr && (is_phase || is_freq) && size_ok && running;
   endsequence

   sequence s_wr_freq_ok;
      req_evt && l_q.wr && is_freq && size_ok && !running && fdec_wr[11];
   endsequence

   busy_reject_a : assert property (s_wr_run |=> busy_fault && c_q.rsp_busy
                    && $stable(c_q.freq) && $stable(c_q.phase))
      else $error("Write while running was not refused");

   off_accept_a : assert property (s_wr_freq_ok |=> c_q.freq == $past(l_q.wdata))
      else $error("Frequency write while off was lost");

   rsvd_zero_a : assert property ((c_q.phase & ~pfil_pkg::PH_WR_MASK) == 8'h00)
      else $error("Reserved phase bits not zero");

   bad_code_a : assert property (req_evt && l_q.wr && is_phase && size_ok && !running
                    && (l_q.wdata[2:0] == 3'h7) |=> cml_fault && $stable(c_q.phase))
      else $error("Bad phase code was accepted");

   len_check_a : assert property (req_evt && is_phase && (l_q.nbytes != 2'h1)
                    |=> c_q.rsp_cml && $stable(c_q.phase))
      else $error("Wrong phase length was accepted");

   ov_detect_a : assert property (vin_sample_vld
                    && (vin_fix > pfil_pkg::lin_to_fix(c_q.vin_ov)) |=> vin_ov_fault)
      else $error("Overvoltage not flagged");

   uv_detect_a : assert property (vin_sample_vld
                    && (vin_fix <= pfil_pkg::lin_to_fix(c_q.vin_uv)) |=> vin_uv_warn)
      else $error("Undervoltage warning not flagged");

   share_hold_a : assert property (vin_sample_vld
                    && (vin_fix < pfil_pkg::lin_to_fix(c_q.input_stop_threshold))
                    && !(vin_fix > pfil_pkg::lin_to_fix(c_q.input_start_threshold))
                    ##1 c_q.phase[pfil_pkg::PH_SHARE_BIT] |-> !share_clk_oe_b)
      else $error("Share clock not pulled below stop level");

   share_free_a : assert property (share_clk_oe_b && !c_q.phase[pfil_pkg::PH_SHARE_BIT]
                    ##1 !c_q.phase[pfil_pkg::PH_SHARE_BIT] |-> share_clk_oe_b)
      else $error("Share clock pulled after first power");

endmodule : pfil_cmd_regs
`default_nettype wire

// ### bench/pfil_host_model.sv
// Bus host model: issues one command at a time on the link
`timescale 1ns/1ps
`default_nettype none
module pfil_host_model
(
   input  wire logic        lnk_clk,
   input  wire logic        lnk_ready,
   input  wire logic        lnk_done,
   input  wire logic [15:0] lnk_rdata,
   input  wire logic        lnk_busy_err,
   input  wire logic        lnk_cml_err,
   output logic             lnk_req,
   output logic             lnk_wr,
   output logic [7:0]       lnk_cmd,
   output logic [1:0]       lnk_nbytes,
   output logic [15:0]      lnk_wdata
);
   // ----------------------------------------------------------------
   // Idle levels
   // ----------------------------------------------------------------
   initial
   begin
      lnk_req    = 1'b0;
      lnk_wr     = 1'b0;
      lnk_cmd    = 8'h00;
      lnk_nbytes = 2'h0;
      lnk_wdata  = 16'h0000;
   end
   // ----------------------------------------------------------------
   // One transfer; released qualifiers are scrambled
   // ----------------------------------------------------------------
   task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [1:0] nb,
                       input logic [15:0] wd, output logic [15:0] rd,
                       output logic [1:0] flg, output logic ok);
      int n;
      n  = 0;
      ok = 1'b0;
      @(negedge lnk_clk);
      while (lnk_ready !== 1'b1 && n < 20)
      begin
         n = n + 1;
         @(negedge lnk_clk);
      end
      lnk_req    = 1'b1;
      lnk_wr     = wr;
      lnk_cmd    = cmd;
      lnk_nbytes = nb;  // Word commands two bytes, phase one
      lnk_wdata  = wd;
      @(negedge lnk_clk);
      lnk_req    = 1'b0;
      lnk_wr     = ~wr;
      lnk_cmd    = ~cmd;
      lnk_nbytes = ~nb;
      lnk_wdata  = ~wd;
      n = 0;
      while (lnk_done !== 1'b1 && n < 20)
      begin
         n = n + 1;
         @(negedge lnk_clk);
      end
      ok  = lnk_done;
      rd  = lnk_rdata;
      flg = {lnk_busy_err, lnk_cml_err};
   endtask : xfer
endmodule : pfil_host_model
`default_nettype wire

// ### bench/tb_top.sv
// Testbench for the command register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic wr; logic [7:0] cmd; logic [1:0] nb; logic [15:0] wd, ex; logic [1:0] fl;
   } pfil_tb_row_t;
   localparam pfil_tb_row_t ROWS[17] = '{
      '{1'b0, 8'hf5, 2'h1, 16'h0, 16'h0010, 2'h0}, '{1'b0, 8'h33, 2'h2, 16'h0, 16'hfabc, 2'h0},
      '{1'b0, 8'h35, 2'h2, 16'h0, 16'hcb40, 2'h0}, '{1'b0, 8'h36, 2'h2, 16'h0, 16'hcb00, 2'h0},
      '{1'b0, 8'h55, 2'h2, 16'h0, 16'hd3e0, 2'h0}, '{1'b0, 8'h58, 2'h2, 16'h0, 16'hcb26, 2'h0},
      '{1'b1, 8'hf5, 2'h1, 16'h00ff, 16'h0, 2'h1}, '{1'b0, 8'hf5, 2'h1, 16'h0, 16'h0010, 2'h0},
      '{1'b1, 8'hf5, 2'h1, 16'h00f6, 16'h0, 2'h0}, '{1'b0, 8'hf5, 2'h1, 16'h0, 16'h0096, 2'h0},
      '{1'b1, 8'hf5, 2'h2, 16'h0000, 16'h0, 2'h1}, '{1'b1, 8'h33, 2'h2, 16'h1234, 16'h0, 2'h1},
      '{1'b1, 8'h33, 2'h1, 16'hf3e8, 16'h0, 2'h1}, '{1'b0, 8'h33, 2'h2, 16'h0, 16'hfabc, 2'h0},
      '{1'b1, 8'h35, 2'h2, 16'hcb80, 16'h0, 2'h0}, '{1'b0, 8'h35, 2'h2, 16'h0, 16'hcb80, 2'h0},
      '{1'b0, 8'h20, 2'h2, 16'h0, 16'h0, 2'h1}};
   localparam logic [15:0] FW[9] = '{16'h0000, 16'hf3e8, 16'hfabc, 16'hfb52, 16'hfbe8,
                                    16'h023f, 16'h028a, 16'h02ee, 16'h03e8};
   localparam logic [9:0]  FK[9] = '{10'd0, 10'd250, 10'd350, 10'd425, 10'd500,
                                    10'd575, 10'd650, 10'd750, 10'd1000};
   localparam logic [8:0]  D0[7] = '{9'd0, 9'd90, 9'd0, 9'd0, 9'd120, 9'd60, 9'd120};
   localparam logic [8:0]  D1[7] = '{9'd180, 9'd270, 9'd240, 9'd120, 9'd240, 9'd240, 9'd300};
   logic ref_clk = 1'b0, rst_b = 1'b0, lnk_clk = 1'b0, lnk_rst_b = 1'b0;
   logic lnk_req, lnk_wr, lnk_ready, lnk_done, lnk_busy_err, lnk_cml_err;
   logic [7:0] lnk_cmd;
   logic [1:0] lnk_nbytes, run_pin = 2'h0, chan_cmd_on = 2'h0, flg;
   logic [15:0] lnk_wdata, lnk_rdata, vin_sample = 16'h0, rd;
   logic vin_sample_vld = 1'b0, clear_faults = 1'b0, ok;
   logic [2:0] phase_code;
   logic [8:0] ch0_phase_deg, ch1_phase_deg;
   logic [9:0] freq_khz;
   logic ea_gang, freq_ext_osc, freq_changed, share_clk_o, share_clk_oe_b;
   logic vin_ov_fault, vin_uv_warn, busy_fault, cml_fault;
   int err_count = 0, checks = 0, cyc = 0, fchg = 0, f0;
   always #2.5 ref_clk = ~ref_clk;
   always #32 lnk_clk = ~lnk_clk;
   pfil_cmd_regs dut (.ref_clk(ref_clk), .rst_b(rst_b), .lnk_clk(lnk_clk),
      .lnk_rst_b(lnk_rst_b), .lnk_req(lnk_req), .lnk_wr(lnk_wr), .lnk_cmd(lnk_cmd),
      .lnk_nbytes(lnk_nbytes), .lnk_wdata(lnk_wdata), .lnk_ready(lnk_ready),
      .lnk_done(lnk_done), .lnk_rdata(lnk_rdata), .lnk_busy_err(lnk_busy_err),
      .lnk_cml_err(lnk_cml_err), .run_pin(run_pin), .chan_cmd_on(chan_cmd_on),
      .vin_sample_vld(vin_sample_vld), .vin_sample(vin_sample), .clear_faults(clear_faults),
      .phase_code(phase_code), .ch0_phase_deg(ch0_phase_deg), .ch1_phase_deg(ch1_phase_deg),
      .ea_gang(ea_gang), .freq_khz(freq_khz), .freq_ext_osc(freq_ext_osc),
      .freq_changed(freq_changed), .share_clk_o(share_clk_o), .share_clk_oe_b(share_clk_oe_b),
      .vin_ov_fault(vin_ov_fault), .vin_uv_warn(vin_uv_warn), .busy_fault(busy_fault),
      .cml_fault(cml_fault));
   pfil_host_model host (.lnk_clk(lnk_clk), .lnk_ready(lnk_ready), .lnk_done(lnk_done),
      .lnk_rdata(lnk_rdata), .lnk_busy_err(lnk_busy_err), .lnk_cml_err(lnk_cml_err),
      .lnk_req(lnk_req), .lnk_wr(lnk_wr), .lnk_cmd(lnk_cmd), .lnk_nbytes(lnk_nbytes),
      .lnk_wdata(lnk_wdata));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
      checks = checks + 1;
      if (got !== ex)
      begin
         err_count = err_count + 1;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic xf(input logic w, input logic [7:0] c, input logic [1:0] n,
                     input logic [15:0] d, input logic [15:0] ex, input logic [1:0] fl);
      host.xfer(w, c, n, d, rd, flg, ok);
      chk("done", 16'h1, {15'h0, ok});
      chk("rdata", ex, rd);
      chk("flags", {14'h0, fl}, {14'h0, flg});
   endtask : xf
   task automatic samp(input logic [15:0] v);
      @(negedge ref_clk);
      vin_sample_vld = 1'b1;
      vin_sample = v;
      @(negedge ref_clk);
      vin_sample_vld = 1'b0;
      vin_sample = ~v;
      repeat (2) @(negedge ref_clk);
   endtask : samp
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out
   always @(negedge ref_clk)
   begin
      cyc = cyc + 1;
      fchg = fchg + int'(freq_changed === 1'b1);
      if (cyc == 20000)
      begin
         err_count = err_count + 1;
         close_out();
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (6) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (3) @(negedge lnk_clk);
      lnk_rst_b = 1'b1;
      chk("share_oe_b", 16'h0, {15'h0, share_clk_oe_b});
      chk("share_o", 16'h0, {15'h0, share_clk_o});
      chk("faults", 16'h0, {12'h0, vin_ov_fault, vin_uv_warn, busy_fault, cml_fault});
      $display("test reset done");
      foreach (ROWS[i])
         xf(ROWS[i].wr, ROWS[i].cmd, ROWS[i].nb, ROWS[i].wd, ROWS[i].ex, ROWS[i].fl);
      chk("ea_gang", 16'h1, {15'h0, ea_gang});
      chk("cml_fault", 16'h1, {15'h0, cml_fault});
      $display("test table done");
      samp(16'hd300);
      chk("share_oe_b", 16'h1, {15'h0, share_clk_oe_b});
      samp(16'hcb20);
      chk("share_oe_b", 16'h1, {15'h0, share_clk_oe_b});
      chk("uv_warn", 16'h1, {15'h0, vin_uv_warn});
      chk("ov_fault", 16'h0, {15'h0, vin_ov_fault});
      samp(16'hca80);
      chk("share_oe_b", 16'h0, {15'h0, share_clk_oe_b});
      samp(16'hda00);
      chk("ov_fault", 16'h1, {15'h0, vin_ov_fault});
      $display("test monitor done");
      run_pin = 2'h3;
      chan_cmd_on = 2'h1;
      repeat (4) @(negedge ref_clk);
      xf(1'b1, 8'hf5, 2'h1, 16'h0000, 16'h0, 2'h2);
      xf(1'b1, 8'h33, 2'h2, 16'hf3e8, 16'h0, 2'h2);
      xf(1'b0, 8'hf5, 2'h1, 16'h0, 16'h0096, 2'h0);
      chk("busy_fault", 16'h1, {15'h0, busy_fault});
      chan_cmd_on = 2'h0;
      xf(1'b1, 8'hf5, 2'h1, 16'h0096, 16'h0, 2'h0);
      run_pin = 2'h0;
      chan_cmd_on = 2'h3;
      repeat (4) @(negedge ref_clk);
      xf(1'b1, 8'hf5, 2'h1, 16'h0016, 16'h0, 2'h0);
      @(negedge ref_clk);
      clear_faults = 1'b1;
      @(negedge ref_clk);
      clear_faults = 1'b0;
      @(negedge ref_clk);
      chk("faults", 16'h0, {12'h0, vin_ov_fault, vin_uv_warn, busy_fault, cml_fault});
      $display("test busy done");
      f0 = fchg;
      for (int i = 0; i < 9; i++)
      begin
         xf(1'b1, 8'h33, 2'h2, FW[i], 16'h0, 2'h0);
         chk("freq_khz", {6'h0, FK[i]}, {6'h0, freq_khz});
         chk("ext_osc", {15'h0, i == 0}, {15'h0, freq_ext_osc});
      end
      xf(1'b1, 8'h33, 2'h2, 16'h03e8, 16'h0, 2'h0);
      chk("freq_chg", 16'd9, 16'(fchg - f0));
      for (int i = 0; i < 7; i++)
      begin
         xf(1'b1, 8'hf5, 2'h1, {13'h0, 3'(i)}, 16'h0, 2'h0);
         chk("ph_code", {13'h0, 3'(i)}, {13'h0, phase_code});
         chk("ch0_deg", {7'h0, D0[i]}, {7'h0, ch0_phase_deg});
         chk("ch1_deg", {7'h0, D1[i]}, {7'h0, ch1_phase_deg});
      end
      chk("ea_gang", 16'h0, {15'h0, ea_gang});
      samp(16'hca80);
      chk("share_oe_b", 16'h1, {15'h0, share_clk_oe_b});
      $display("test decode done");
      close_out();
   end
endmodule : tb_top
`default_nettype wire
